// File: src/etd_pkg.sv
// Shared constants, register map and types for the EEPROM timebase divider controller
package etd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ETD_OFS_DIV_HI = 8'h00;
  localparam logic [7:0] ETD_OFS_DIV_LO = 8'h04;
  localparam logic [7:0] ETD_OFS_SH_HI = 8'h08;
  localparam logic [7:0] ETD_OFS_SH_LO = 8'h0c;
  localparam logic [7:0] ETD_OFS_CTRL = 8'h10;
  localparam logic [7:0] ETD_OFS_STAT = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Field layout and values after reset
  localparam int ETD_DIV_W = 11;
  localparam int ETD_LOCK_BIT = 7;
  localparam int ETD_LOST_BIT = 4;
  localparam logic [7:0] ETD_DIVH_MASK = 8'h87;
  localparam logic [7:0] ETD_DIVH_RST = 8'h00;
  localparam logic [7:0] ETD_DIVL_RST = 8'h00;
  localparam logic [7:0] ETD_SHADOW_FACTORY = 8'hff;
  localparam logic [7:0] ETD_ERASED = 8'hff;
  localparam int ETD_TICK_US = 35;
  localparam int ETD_SEQ_TICKS = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic ref_sel;
    logic erase_sel;
    logic bus_latch;
    logic pump_en;
  } etd_ctrl_t;

  typedef struct packed {
    logic wait_seen;
    logic armed;
    logic lost;
    logic blocked;
    logic deny;
    logic hv_on;
    logic busy;
  } etd_stat_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_HALT = 4'b0100,
    ST_DONE = 4'b1000
  } etd_state_t;

  typedef enum logic [1:0] {
    TGT_NONE = 2'h0,
    TGT_ARR = 2'h1,
    TGT_HI = 2'h2,
    TGT_LO = 2'h3
  } etd_tgt_t;

  function automatic logic etd_hit(input logic [7:0] a, input logic [7:0] o);
    etd_hit = (a == o);
  endfunction : etd_hit

endpackage : etd_pkg

// File: src/etd_tickgen.sv
// Timebase counter that divides the selected reference rate into a tick
`timescale 1ns/1ps
module etd_tickgen #(
  parameter int DIV_W = 11
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic run, // Counter may advance
  input wire logic ref_en, // One reference period elapsed
  input wire logic [DIV_W-1:0] divisor, // Terminal count
  output logic tick // One-cycle timebase pulse
);
  logic [DIV_W-1:0] cnt_q;
  logic tick_q;
  wire hit = run && ref_en && (cnt_q == divisor);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= hit; // R15
      if (hit) begin
        cnt_q <= '0; // R15
      end else if (run && ref_en) begin
        cnt_q <= cnt_q + 1'b1; // R01
      end
    end
  end

  assign tick = tick_q;

  a_tick_wrap: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    hit |=> tick && cnt_q == '0) else $error("tick not issued at terminal count");
  a_tick_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R01
    !run |=> $stable(cnt_q) && !tick) else $error("counter moved while halted");
endmodule : etd_tickgen

// File: src/etd_nvbyte.sv
// One nonvolatile shadow byte, kept across system reset, erased or programmed on commit
`timescale 1ns/1ps
module etd_nvbyte #(
  parameter logic [7:0] FACTORY = 8'hff
) (
  input wire logic hclk, // System clock
  input wire logic por_n, // Power-on reset, active low
  input wire logic commit, // Finish an erase or program
  input wire logic erase, // 1 erase, 0 program
  input wire logic [7:0] wdata, // Byte to program
  output logic [7:0] q // Stored byte
);
  import etd_pkg::*;

  logic [7:0] mem_q;

  // Only power-on loads the factory byte; system reset must not touch the stored byte
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      mem_q <= FACTORY;
    end else if (commit) begin
      mem_q <= erase ? ETD_ERASED : wdata;
    end
  end

  assign q = mem_q;
endmodule : etd_nvbyte

// File: src/etd_ctrl.sv
// Top: EEPROM timebase divider registers, shadow bytes and stop/wait sequencing
//
// How it works
// R01 - 11-bit divisor divides selected reference into tick
// R02 - Divisor reads always; writes need latch 0, unlock
// R03 - Software picks divisor as rounded frequency times 35us
// R04 - Software loads divisor before any program or erase
// R05 - Every reset copies shadow bytes into divider registers
// R06 - Shadows erased and programmed like array bytes
// R07 - Shadow operations blocked when lock bit is one
// R08 - Shadow lock zero at reset locks everything forever
// R09 - Wait mode leaves running sequence untouched
// R10 - Stop cuts power; software avoids stop mid-sequence
// R11 - Stop with latch and pump halts, restarts, denies
// R12 - Stop with latch only aborts; data integrity lost
// R13 - Lock bit one unlocked, zero locks both registers
// R14 - Bus latch configures buses for programming; reset clears
// R15 - Counter ticks once at divisor, then restarts
`timescale 1ns/1ps
module etd_ctrl
  import etd_pkg::*;
#(
  parameter int SEQ_TICKS = etd_pkg::ETD_SEQ_TICKS,
  parameter logic [7:0] FACTORY_HI = etd_pkg::ETD_SHADOW_FACTORY,
  parameter logic [7:0] FACTORY_LO = etd_pkg::ETD_SHADOW_FACTORY
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // System reset, active low
  input wire logic por_n, // Power-on reset for shadow bytes
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic hready, // Bus ready in
  input wire logic [31:0] hwdata, // Write data
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Always ready
  output logic hresp, // Always OKAY
  input wire logic xtal_ref_en, // Crystal reference period pulse
  input wire logic stop_mode, // Processor in stop
  input wire logic wait_mode, // Processor in wait
  input wire logic arr_wr, // Array byte written while latched
  output logic tb_tick, // Timebase tick pulse
  output logic hv_on, // High voltage applied
  output logic array_deny // Array access refused
);
  import etd_pkg::*;

  localparam int CW = $clog2(SEQ_TICKS) + 1;
  localparam logic [CW-1:0] SEQ_LAST = CW'(SEQ_TICKS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  logic wr_pend_q;
  logic [7:0] wa_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_d;
  wire acc = hsel && hready && htrans[1];
  wire [7:0] aa = haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wa_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= acc && hwrite;
      if (acc) begin
        wa_q <= aa;
      end
      if (acc && !hwrite) begin
        hrdata_q <= rd_d;
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire w_dh = wr_pend_q && etd_hit(wa_q, ETD_OFS_DIV_HI);
  wire w_dl = wr_pend_q && etd_hit(wa_q, ETD_OFS_DIV_LO);
  wire w_sh = wr_pend_q && etd_hit(wa_q, ETD_OFS_SH_HI);
  wire w_sl = wr_pend_q && etd_hit(wa_q, ETD_OFS_SH_LO);
  wire w_ct = wr_pend_q && etd_hit(wa_q, ETD_OFS_CTRL);
  wire w_st = wr_pend_q && etd_hit(wa_q, ETD_OFS_STAT);

  ////////////////////////////////////////////////////////////////////////////
  // Divider registers and reset load from the shadows
  logic [7:0] div_hi_q;
  logic [7:0] div_lo_q;
  logic load_q;
  logic armed_q;
  logic [7:0] sh_hi;
  logic [7:0] sh_lo;
  etd_ctrl_t ctrl_q;

  wire lock_live = div_hi_q[ETD_LOCK_BIT];
  wire div_wr_ok = !ctrl_q.bus_latch && lock_live && !load_q; // R02 R13

  // Shadows are caught one edge after release, never by the reset itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_q <= 1'b1;
      armed_q <= 1'b0;
      div_hi_q <= ETD_DIVH_RST;
      div_lo_q <= ETD_DIVL_RST;
    end else if (load_q) begin
      load_q <= 1'b0;
      div_hi_q <= sh_hi & ETD_DIVH_MASK; // R05 R08
      div_lo_q <= sh_lo; // R05
      armed_q <= !sh_hi[ETD_LOCK_BIT]; // R08
    end else begin
      if (w_dh && div_wr_ok) begin
        div_hi_q <= hwdata[7:0] & ETD_DIVH_MASK; // R02
      end
      if (w_dl && div_wr_ok) begin
        div_lo_q <= hwdata[7:0]; // R02
      end
    end
  end

  wire [ETD_DIV_W-1:0] divisor = {div_hi_q[2:0], div_lo_q}; // R01

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= '0; // R14
    end else if (w_ct) begin
      ctrl_q <= etd_ctrl_t'(hwdata[3:0]); // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase
  // Bus clock reference counts every hclk; crystal needs its period pulse
  wire ref_en = ctrl_q.ref_sel ? xtal_ref_en : 1'b1; // R01
  wire tick;

  // Stop freezes the divider so the timebase draws no switching power
  etd_tickgen #(
    .DIV_W(ETD_DIV_W)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(!stop_mode), // R10
    .ref_en(ref_en),
    .divisor(divisor),
    .tick(tick)
  );

  assign tb_tick = tick;

  ////////////////////////////////////////////////////////////////////////////
  // Program and erase sequence
  etd_state_t st_q;
  etd_state_t st_d;
  etd_tgt_t tgt_q;
  logic [7:0] data_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic commit;
  logic abort;
  logic lost_set;
  logic lost_q;

  wire latch = ctrl_q.bus_latch;
  wire pump = ctrl_q.pump_en;
  wire pend = (tgt_q != TGT_NONE);
  wire blocked = lock_live || sh_hi[ETD_LOCK_BIT] || armed_q; // R07 R08

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    commit = 1'b0;
    abort = 1'b0;
    lost_set = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (stop_mode && latch && pend) begin
          abort = 1'b1; // R12
          lost_set = 1'b1; // R12
        end else if (!stop_mode && latch && pump && pend) begin
          st_d = ST_RUN; // R06
          cnt_d = '0;
        end
      end
      ST_RUN: begin
        if (stop_mode) begin
          lost_set = 1'b1; // R12
          if (latch && pump) begin
            st_d = ST_HALT; // R11
          end else begin
            st_d = ST_IDLE; // R12
            abort = 1'b1;
          end
        end else if (!(latch && pump)) begin
          st_d = ST_IDLE;
          abort = 1'b1;
        end else if (tick) begin
          // Wait mode is not looked at here: the sequence keeps going
          if (cnt_q == SEQ_LAST) begin
            st_d = ST_DONE; // R09
            commit = 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1; // R09
          end
        end
      end
      ST_HALT: begin
        if (!stop_mode) begin
          st_d = ST_RUN; // R11
          cnt_d = '0; // R11
        end
      end
      ST_DONE: begin
        if (!pump) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  wire idle = (st_q == ST_IDLE);
  wire take_sh = latch && idle && !stop_mode;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      tgt_q <= TGT_NONE;
      data_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      if (commit || abort || !latch) begin
        tgt_q <= TGT_NONE;
      end else if (take_sh && w_sh) begin
        tgt_q <= TGT_HI; // R06
        data_q <= hwdata[7:0];
      end else if (take_sh && w_sl) begin
        tgt_q <= TGT_LO; // R06
        data_q <= hwdata[7:0];
      end else if (take_sh && arr_wr) begin
        tgt_q <= TGT_ARR;
      end
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lost_q <= 1'b0;
    end else if (lost_set) begin
      lost_q <= 1'b1; // R12
    end else if (w_st && hwdata[ETD_LOST_BIT]) begin
      lost_q <= 1'b0;
    end
  end

  wire commit_hi = commit && (tgt_q == TGT_HI) && !blocked; // R07
  wire commit_lo = commit && (tgt_q == TGT_LO) && !blocked; // R07

  etd_nvbyte #(
    .FACTORY(FACTORY_HI)
  ) u_sh_hi (
    .hclk(hclk),
    .por_n(por_n),
    .commit(commit_hi),
    .erase(ctrl_q.erase_sel),
    .wdata(data_q),
    .q(sh_hi)
  );

  etd_nvbyte #(
    .FACTORY(FACTORY_LO)
  ) u_sh_lo (
    .hclk(hclk),
    .por_n(por_n),
    .commit(commit_lo),
    .erase(ctrl_q.erase_sel),
    .wdata(data_q),
    .q(sh_lo)
  );

  assign hv_on = (st_q == ST_RUN) && !stop_mode; // R11
  assign array_deny = (st_q == ST_RUN) || (st_q == ST_HALT); // R11

  ////////////////////////////////////////////////////////////////////////////
  // Read selection
  etd_stat_t stat;
  assign stat = '{wait_seen: wait_mode, armed: armed_q, lost: lost_q,
                  blocked: blocked, deny: array_deny, hv_on: hv_on, busy: !idle};

  wire [7:0] sh_hi_rd = array_deny ? 8'h00 : sh_hi;
  wire [7:0] sh_lo_rd = array_deny ? 8'h00 : sh_lo;

  assign rd_d = etd_hit(aa, ETD_OFS_DIV_HI) ? {24'h000000, div_hi_q} : // R02
                etd_hit(aa, ETD_OFS_DIV_LO) ? {24'h000000, div_lo_q} :
                etd_hit(aa, ETD_OFS_SH_HI) ? {24'h000000, sh_hi_rd} :
                etd_hit(aa, ETD_OFS_SH_LO) ? {24'h000000, sh_lo_rd} :
                etd_hit(aa, ETD_OFS_CTRL) ? {28'h0000000, ctrl_q} :
                etd_hit(aa, ETD_OFS_STAT) ? {25'h0000000, stat} :
                32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_div_write_gate: assert property ( // R02
    (w_dl && !div_wr_ok && !load_q) |=> $stable(div_lo_q))
    else $error("divisor changed by a refused write");
  a_div_write_take: assert property ( // R02
    (w_dl && div_wr_ok) |=> div_lo_q == $past(hwdata[7:0]))
    else $error("divisor write not taken");
  a_reset_load: assert property ( // R05
    load_q |=> div_lo_q == $past(sh_lo) && div_hi_q == ($past(sh_hi) & ETD_DIVH_MASK))
    else $error("shadow not copied at reset");
  a_armed_lock: assert property ( // R08
    (armed_q && !load_q) |-> !lock_live && !div_wr_ok && blocked)
    else $error("armed security did not lock");
  a_shadow_block: assert property ( // R07
    (commit && blocked) |=> $stable(sh_hi) && $stable(sh_lo))
    else $error("shadow changed while blocked");
  a_stop_halt: assert property ( // R11
    (st_q == ST_RUN && stop_mode && latch && pump) |=> st_q == ST_HALT && !hv_on && array_deny)
    else $error("stop did not halt the sequence");
  a_stop_abort: assert property ( // R12
    (st_q == ST_RUN && stop_mode && latch && !pump) |=> st_q == ST_IDLE && lost_q)
    else $error("stop with pump off did not abort");
  a_halt_restart: assert property ( // R11
    (st_q == ST_HALT && !stop_mode) |=> st_q == ST_RUN && cnt_q == '0)
    else $error("sequence did not restart after stop");
  a_wait_keep: assert property ( // R09
    (st_q == ST_RUN && wait_mode && !stop_mode && latch && pump && !tick) |=> st_q == ST_RUN)
    else $error("wait disturbed the sequence");
  a_latch_clear: assert property ( // R14
    load_q |-> ctrl_q == '0)
    else $error("bus latch not cleared by reset");

  c_seq_done: cover property (st_q == ST_RUN ##1 st_q == ST_DONE);
  c_stop_halt: cover property (st_q == ST_HALT ##[1:50] st_q == ST_RUN);
  c_shadow_prog: cover property (commit_hi || commit_lo);
  c_stop_abort: cover property (abort && lost_set);
endmodule : etd_ctrl

// File: sim/etd_ctrl_bench.sv
// Self-checking bench for the timebase divider controller, driven over AHB-Lite
`timescale 1ns/1ps
module etd_ctrl_bench;
  import etd_pkg::*;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic por_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic xtal_ref_en = 1'b0;
  logic stop_mode = 1'b0;
  logic wait_mode = 1'b0;
  logic arr_wr = 1'b0;
  logic [31:0] hrdata, hrdata2, rdata, rdata2;
  logic hreadyout, hresp, tb_tick, hv_on, array_deny;
  int mismatches = 0;
  int tests_run = 0;
  int tick_count = 0;
  int t0;

  always #2.5 hclk = ~hclk;

  // Crystal reference at half the bus rate, one pulse every second cycle
  always @(posedge hclk) xtal_ref_en <= ~xtal_ref_en;
  always @(posedge hclk) if (tb_tick === 1'b1) tick_count++;

  ////////////////////////////////////////////////////////////////////////////
  // Main instance with erased shadows; a second one whose shadow lock bit reads 0
  etd_ctrl #(.SEQ_TICKS(2)) dut (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .xtal_ref_en(xtal_ref_en), .stop_mode(stop_mode), .wait_mode(wait_mode),
    .arr_wr(arr_wr), .tb_tick(tb_tick), .hv_on(hv_on), .array_deny(array_deny)
  );

  etd_ctrl #(.SEQ_TICKS(2), .FACTORY_HI(8'h05), .FACTORY_LO(8'h33)) dut_locked (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata2), .hreadyout(), .hresp(),
    .xtal_ref_en(xtal_ref_en), .stop_mode(stop_mode), .wait_mode(wait_mode),
    .arr_wr(arr_wr), .tb_tick(), .hv_on(), .array_deny()
  );

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task print_verdict;
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // Both instances answer every transfer; the master never counts wait states
  task bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= is_wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
    rdata2 = hrdata2;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd

  task wait_hv(input logic v);
    int n;
    n = 0;
    while (hv_on !== v && n < 1000) begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk({31'h0, hv_on}, {31'h0, v});
  endtask : wait_hv

  task set_stop(input logic v);
    @(posedge hclk);
    stop_mode <= v;
    @(posedge hclk);
    #1;
  endtask : set_stop

  task ticks_in(input int cycles, input int exp);
    @(posedge hclk);
    #1 t0 = tick_count;
    repeat (cycles) @(posedge hclk);
    #1 chk(tick_count - t0, exp);
  endtask : ticks_in

  task sys_reset;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask : sys_reset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_reset();
    rd(ETD_OFS_DIV_HI, {24'h0, ETD_SHADOW_FACTORY & ETD_DIVH_MASK});
    chk(rdata2, 32'h05);
    rd(ETD_OFS_DIV_LO, {24'h0, ETD_SHADOW_FACTORY});
    chk(rdata2, 32'h33);
    rd(ETD_OFS_SH_HI, {24'h0, ETD_SHADOW_FACTORY});
    rd(ETD_OFS_CTRL, 32'h0);
    // Load a mid-size divisor early, while the counter is still below it
    wr(ETD_OFS_DIV_HI, 32'hf8);
    wr(ETD_OFS_DIV_LO, 32'h40);
    rd(ETD_OFS_DIV_HI, 32'h80);
    chk(rdata2, 32'h05);
    rd(ETD_OFS_DIV_LO, 32'h40);
    chk(rdata2, 32'h33);
    rd(8'h20, 32'h0);
    ticks_in(650, 10);
    wr(ETD_OFS_CTRL, 32'h8);
    rd(ETD_OFS_CTRL, 32'h8);
    ticks_in(1300, 10);
    wr(ETD_OFS_CTRL, 32'h0);
    // Divisor frozen while the buses are latched
    wr(ETD_OFS_CTRL, 32'h2);
    wr(ETD_OFS_DIV_LO, 32'h11);
    rd(ETD_OFS_DIV_LO, 32'h40);
    // Full sequence interrupted by stop with latch and pump set
    wr(ETD_OFS_SH_LO, 32'h00);
    wr(ETD_OFS_CTRL, 32'h3);
    wait_hv(1'b1);
    chk({31'h0, array_deny}, 32'h1);
    wait_mode <= 1'b1;
    rd(ETD_OFS_STAT, 32'h4f);
    wait_mode <= 1'b0;
    set_stop(1'b1);
    chk({31'h0, hv_on}, 32'h0);
    rd(ETD_OFS_STAT, 32'h1d);
    rd(ETD_OFS_SH_HI, 32'h0);
    set_stop(1'b0);
    wait_hv(1'b1);
    wait_hv(1'b0);
    chk({31'h0, array_deny}, 32'h0);
    rd(ETD_OFS_SH_LO, {24'h0, ETD_SHADOW_FACTORY});
    wr(ETD_OFS_CTRL, 32'h2);
    wr(ETD_OFS_CTRL, 32'h0);
    wr(ETD_OFS_STAT, 32'h10);
    rd(ETD_OFS_STAT, 32'h08);
    // Stop with latch only drops the pending operation
    wr(ETD_OFS_CTRL, 32'h2);
    wr(ETD_OFS_SH_HI, 32'h00);
    set_stop(1'b1);
    set_stop(1'b0);
    rd(ETD_OFS_STAT, 32'h18);
    wr(ETD_OFS_CTRL, 32'h3);
    repeat (3) @(posedge hclk);
    #1 chk({31'h0, hv_on}, 32'h0);
    wr(ETD_OFS_CTRL, 32'h2);
    wr(ETD_OFS_CTRL, 32'h0);
    // Clearing the live lock bit freezes both divider registers
    wr(ETD_OFS_DIV_HI, 32'h00);
    rd(ETD_OFS_DIV_HI, 32'h00);
    wr(ETD_OFS_DIV_LO, 32'h11);
    rd(ETD_OFS_DIV_LO, 32'h40);
    wr(ETD_OFS_DIV_HI, 32'h80);
    rd(ETD_OFS_DIV_HI, 32'h00);
    // System reset alone reloads the live registers from the shadows
    sys_reset();
    rd(ETD_OFS_DIV_HI, {24'h0, ETD_SHADOW_FACTORY & ETD_DIVH_MASK});
    rd(ETD_OFS_DIV_LO, {24'h0, ETD_SHADOW_FACTORY});
    print_verdict();
  end

  // About 2,200 cycles expected; a hang ends the run at the 20,000-cycle budget, about nine times that
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    print_verdict();
  end

endmodule : etd_ctrl_bench
